// [logic/exec_pkg.sv]
// Purpose: shared types and constants for the instruction execute core
// Assumes: 8-bit data path, 16-bit program words
// Notes:   operation codes are the core's own encoding
package exec_pkg;
  localparam int          DW          = 8;
  localparam int          AW          = 9;
  localparam int          PW          = 16;
  localparam logic [7:0]  SYS_BASE    = 8'h80;
  localparam logic [7:0]  IMM_REG_LO  = 8'h80;
  localparam logic [7:0]  IMM_REG_HI  = 8'h87;
  localparam logic [2:0]  COST_ONE    = 3'h1;
  localparam logic [2:0]  COST_TABLE  = 3'h2;
  localparam logic [7:0]  ACC_RESET   = 8'h00;

  typedef enum logic [5:0] {
    OP_NOP      = 6'h00, OP_MOV_AM  = 6'h01, OP_MOV_MA  = 6'h02,
    OP_B0MOV_AM = 6'h03, OP_B0MOV_MA = 6'h04, OP_MOV_AI = 6'h05,
    OP_B0MOV_MI = 6'h06, OP_XCH     = 6'h07, OP_BZ_XCH  = 6'h08,
    OP_TBLRD    = 6'h09, OP_ADC_AM  = 6'h0A, OP_ADC_MA  = 6'h0B,
    OP_ADD_AM   = 6'h0C, OP_ADD_MA  = 6'h0D, OP_B0ADD   = 6'h0E,
    OP_ADD_AI   = 6'h0F, OP_SBC_AM  = 6'h10, OP_SBC_MA  = 6'h11,
    OP_SUB_AM   = 6'h12, OP_SUB_MA  = 6'h13, OP_SUB_AI  = 6'h14,
    OP_AND_AM   = 6'h15, OP_AND_MA  = 6'h16, OP_AND_AI  = 6'h17,
    OP_OR_AM    = 6'h18, OP_OR_MA   = 6'h19, OP_OR_AI   = 6'h1A,
    OP_XOR_AM   = 6'h1B, OP_XOR_MA  = 6'h1C, OP_XOR_AI  = 6'h1D,
    OP_SWAP     = 6'h1E, OP_SWAP_MEM = 6'h1F, OP_RRC    = 6'h20,
    OP_RRC_MEM  = 6'h21, OP_RLC     = 6'h22, OP_RLC_MEM = 6'h23,
    OP_CLR      = 6'h24, OP_BCLR    = 6'h25, OP_BSET    = 6'h26,
    OP_BZ_BCLR  = 6'h27, OP_BZ_BSET = 6'h28, OP_CMP_SKIP = 6'h29
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } state_t;

  typedef struct packed {
    op_t        op;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [2:0] bitSel;
  } instr_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } flags_t;
endpackage

// [logic/instr_exec.sv]
// Purpose: executes data, arithmetic, logic and bit instructions
// Assumes: data memory answers a read one cycle after memRd
// Notes:   costReg reports the instruction's cycle charge
//
// What this block does
// - immediate move only into registers 0x80..0x87
// - bank-0 exchange, 1+N cycles, flags kept
// - table read fills R and A, 2 cycles
// - add with carry sets C, DC, Z
// - add without carry, to A or to both A and memory
// - bank-0 add writes sum back to memory
// - add immediate, one cycle, C DC Z
// - subtract with borrow, carry means no borrow
// - subtract without carry-in, to A or to both A and memory
// - subtract immediate, same carry convention
// - AND OR XOR touch only Z
// - swap nibbles into accumulator, no flags
// - swap nibbles in place, 1+N, no flags
// - rotate through carry, to A or memory
// - bit clear and set, 1+N, no flags
// - compare immediate, skip when equal, 1+S
// - N is 0 for system registers, else 1
// - S is 1 when skip taken, else 0
`timescale 1ns/10ps
module instr_exec (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // instruction issue
  input  wire logic                issueValid,
  input  wire exec_pkg::instr_t    issueInstr,
  input  wire logic                bankSel,
  output logic                     readyReg,
  output logic                     doneReg,
  output logic [2:0]               costReg,
  output logic                     skipReg,
  // data memory
  output logic [exec_pkg::AW-1:0]  memAddrReg,
  output logic                     memRdReg,
  output logic                     memWrReg,
  output logic [exec_pkg::DW-1:0]  memWdataReg,
  input  wire logic [exec_pkg::DW-1:0] memRdata,
  // program memory
  input  wire logic [7:0]          yValue,
  input  wire logic [7:0]          zValue,
  output logic [exec_pkg::PW-1:0]  progAddrReg,
  output logic                     progRdReg,
  input  wire logic [exec_pkg::PW-1:0] progData,
  // core state
  output logic [exec_pkg::DW-1:0]  accReg,
  output logic [exec_pkg::DW-1:0]  rReg,
  output exec_pkg::flags_t         flagsReg
);
  import exec_pkg::*;

  function automatic logic isBank0(op_t o);
    return o inside {OP_B0MOV_AM, OP_B0MOV_MA, OP_B0MOV_MI, OP_BZ_XCH,
                     OP_B0ADD, OP_BZ_BCLR, OP_BZ_BSET};
  endfunction

  function automatic logic usesImm(op_t o);
    return o inside {OP_MOV_AI, OP_B0MOV_MI, OP_ADD_AI, OP_SUB_AI,
                     OP_AND_AI, OP_OR_AI, OP_XOR_AI, OP_CMP_SKIP};
  endfunction

  // memory-writing forms charged 1+N, except the moves and CLR
  function automatic logic chargesN(op_t o);
    return o inside {OP_XCH, OP_BZ_XCH, OP_ADC_MA, OP_ADD_MA, OP_B0ADD,
                     OP_SBC_MA, OP_SUB_MA, OP_AND_MA, OP_OR_MA, OP_XOR_MA,
                     OP_SWAP_MEM, OP_RRC_MEM, OP_RLC_MEM, OP_BCLR, OP_BSET,
                     OP_BZ_BCLR, OP_BZ_BSET};
  endfunction

  function automatic logic isLogic(op_t o);
    return o inside {OP_AND_AM, OP_AND_MA, OP_AND_AI, OP_OR_AM, OP_OR_MA,
                     OP_OR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_AI};
  endfunction

  function automatic logic isArith(op_t o);
    return o inside {OP_ADC_AM, OP_ADC_MA, OP_ADD_AM, OP_ADD_MA, OP_B0ADD,
                     OP_ADD_AI, OP_SBC_AM, OP_SBC_MA, OP_SUB_AM, OP_SUB_MA,
                     OP_SUB_AI};
  endfunction

  state_t     stateReg;
  instr_t     instrReg;
  logic       sysReg;
  op_t        op;
  logic [7:0] opnd;
  logic [7:0] bEff;
  logic       cin;
  logic       isSub;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] result;
  logic       toMem;
  logic       toAcc;
  logic       newC;
  logic       updC;
  logic       updDc;
  logic       updZ;
  logic       skipNow;

  assign op = instrReg.op;
  assign opnd = usesImm(op) ? instrReg.imm : memRdata;

  // shared adder, subtract as add of inverted operand
  always_comb begin
    isSub = op inside {OP_SBC_AM, OP_SBC_MA, OP_SUB_AM, OP_SUB_MA,
                       OP_SUB_AI, OP_CMP_SKIP};
    bEff = isSub ? ~opnd : opnd;
    case (op)
      OP_ADC_AM, OP_ADC_MA, OP_SBC_AM, OP_SBC_MA: cin = flagsReg.c;
      OP_SUB_AM, OP_SUB_MA, OP_SUB_AI, OP_CMP_SKIP: cin = 1'b1;
      default:                                    cin = 1'b0;
    endcase
    sum9 = {1'b0, accReg} + {1'b0, bEff} + {8'h00, cin};
    sum5 = {1'b0, accReg[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cin};
  end

  // result, destination and flag selection
  always_comb begin
    result = sum9[7:0];
    toMem = 1'b0;
    toAcc = 1'b0;
    newC = sum9[8];
    updC = 1'b0;
    updDc = 1'b0;
    updZ = 1'b0;
    skipNow = 1'b0;
    case (op)
      OP_MOV_AM, OP_B0MOV_AM: begin
        result = memRdata;
        toAcc = 1'b1;
        updZ = 1'b1;
      end
      OP_MOV_MA, OP_B0MOV_MA: begin
        result = accReg;
        toMem = 1'b1;
      end
      OP_MOV_AI: begin
        result = instrReg.imm;
        toAcc = 1'b1;
      end
      OP_B0MOV_MI: begin
        result = instrReg.imm;
        toMem = (instrReg.addr >= IMM_REG_LO) &&
                (instrReg.addr <= IMM_REG_HI);
      end
      OP_XCH, OP_BZ_XCH: begin
        result = accReg;
        toMem = 1'b1;
        toAcc = 1'b1;
      end
      OP_ADC_AM, OP_ADD_AM, OP_ADD_AI, OP_SBC_AM, OP_SUB_AM, OP_SUB_AI: begin
        toAcc = 1'b1;
      end
      OP_ADC_MA, OP_ADD_MA, OP_SBC_MA, OP_SUB_MA: begin
        toMem = 1'b1;
        toAcc = 1'b1;
      end
      OP_B0ADD: begin
        toMem = 1'b1;
      end
      OP_AND_AM, OP_AND_AI: begin
        result = accReg & opnd;
        toAcc = 1'b1;
      end
      OP_OR_AM, OP_OR_AI: begin
        result = accReg | opnd;
        toAcc = 1'b1;
      end
      OP_XOR_AM, OP_XOR_AI: begin
        result = accReg ^ opnd;
        toAcc = 1'b1;
      end
      OP_AND_MA: begin
        result = accReg & opnd;
        toMem = 1'b1;
      end
      OP_OR_MA: begin
        result = accReg | opnd;
        toMem = 1'b1;
      end
      OP_XOR_MA: begin
        result = accReg ^ opnd;
        toMem = 1'b1;
      end
      OP_SWAP, OP_SWAP_MEM: begin
        result = {memRdata[3:0], memRdata[7:4]};
        toAcc = (op == OP_SWAP);
        toMem = (op == OP_SWAP_MEM);
      end
      OP_RRC, OP_RRC_MEM: begin
        result = {flagsReg.c, memRdata[7:1]};
        newC = memRdata[0];
        updC = 1'b1;
        toAcc = (op == OP_RRC);
        toMem = (op == OP_RRC_MEM);
      end
      OP_RLC, OP_RLC_MEM: begin
        result = {memRdata[6:0], flagsReg.c};
        newC = memRdata[7];
        updC = 1'b1;
        toAcc = (op == OP_RLC);
        toMem = (op == OP_RLC_MEM);
      end
      OP_CLR: begin
        result = 8'h00;
        toMem = 1'b1;
      end
      OP_BCLR, OP_BZ_BCLR: begin
        result = memRdata & ~(8'h01 << instrReg.bitSel);
        toMem = 1'b1;
      end
      OP_BSET, OP_BZ_BSET: begin
        result = memRdata | (8'h01 << instrReg.bitSel);
        toMem = 1'b1;
      end
      OP_CMP_SKIP: begin
        updC = 1'b1;
        updZ = 1'b1;
        skipNow = (accReg == instrReg.imm);
      end
      default: begin
        result = sum9[7:0];
      end
    endcase
    if (isArith(op)) begin
      updC = 1'b1;
      updDc = 1'b1;
      updZ = 1'b1;
    end
    if (isLogic(op)) begin
      updZ = 1'b1;
    end
  end

  // sequencing: issue, fetch operand, execute
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= ST_IDLE;
      instrReg <= '0;
      readyReg <= 1'b0;
    end else if (ce) begin
      case (stateReg)
        ST_IDLE: begin
          readyReg <= 1'b1;
          if (issueValid && readyReg) begin
            instrReg <= issueInstr;
            stateReg <= ST_FETCH;
            readyReg <= 1'b0;
          end
        end
        ST_FETCH: stateReg <= ST_EXEC;
        ST_EXEC: begin
          stateReg <= ST_IDLE;
          readyReg <= 1'b1;
        end
        default: stateReg <= ST_IDLE;
      endcase
    end
  end

  // operand and table fetch requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memAddrReg <= '0;
      memRdReg <= 1'b0;
      progAddrReg <= '0;
      progRdReg <= 1'b0;
    end else if (ce) begin
      memRdReg <= 1'b0;
      progRdReg <= 1'b0;
      if (stateReg == ST_IDLE && issueValid && readyReg) begin
        memAddrReg <= {isBank0(issueInstr.op) ? 1'b0 : bankSel,
                       issueInstr.addr};
        memRdReg <= !usesImm(issueInstr.op) &&
                    (issueInstr.op != OP_TBLRD);
        progAddrReg <= {yValue, zValue};
        progRdReg <= (issueInstr.op == OP_TBLRD);
      end
    end
  end

  // write-back to memory and accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memWrReg <= 1'b0;
      memWdataReg <= '0;
      accReg <= ACC_RESET;
      rReg <= '0;
    end else if (ce) begin
      memWrReg <= 1'b0;
      if (stateReg == ST_EXEC) begin
        memWrReg <= toMem;
        memWdataReg <= result;
        if (op == OP_TBLRD) begin
          rReg <= progData[15:8];
          accReg <= progData[7:0];
        end else if (toAcc) begin
          accReg <= (op == OP_XCH || op == OP_BZ_XCH) ? memRdata : result;
        end
      end
    end
  end

  // flags hold unless the operation lists them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flagsReg <= '0;
    end else if (ce && stateReg == ST_EXEC) begin
      if (updC) flagsReg.c <= newC;
      if (updDc) flagsReg.dc <= sum5[4];
      if (updZ)
        flagsReg.z <= (op == OP_CMP_SKIP) ? skipNow : (result == 8'h00);
    end
  end

  // completion, cost and skip
  assign sysReg = (instrReg.addr >= SYS_BASE);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      doneReg <= 1'b0;
      costReg <= '0;
      skipReg <= 1'b0;
    end else if (ce) begin
      doneReg <= (stateReg == ST_EXEC);
      if (stateReg == ST_EXEC) begin
        skipReg <= skipNow;
        if (op == OP_TBLRD)
          costReg <= COST_TABLE;
        else if (chargesN(op))
          costReg <= COST_ONE + {2'b00, !sysReg};
        else
          costReg <= COST_ONE + {2'b00, skipNow};
      end
    end
  end

  property p_imm_reg_range;
    @(posedge clk) disable iff (!arst_n)
      (memWrReg && op == OP_B0MOV_MI) |->
        (memAddrReg[7:0] >= IMM_REG_LO && memAddrReg[7:0] <= IMM_REG_HI);
  endproperty
  a_imm_reg_range: assert property (p_imm_reg_range)
    else $error("immediate move wrote outside system registers");

  property p_xch_flags;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && (op == OP_XCH || op == OP_BZ_XCH)) |-> $stable(flagsReg);
  endproperty
  a_xch_flags: assert property (p_xch_flags)
    else $error("exchange changed flags");

  property p_table_cost;
    @(posedge clk) disable iff (!arst_n)
      (ce && progRdReg) |=> ##1 (doneReg && costReg == 3'h2);
  endproperty
  a_table_cost: assert property (p_table_cost)
    else $error("table read not charged two cycles");

  property p_add_imm;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && op == OP_ADD_AI) |->
        (accReg == 8'($past(accReg) + instrReg.imm) &&
         flagsReg.c == (({1'b0, $past(accReg)} + {1'b0, instrReg.imm})
                        > 9'h0FF));
  endproperty
  a_add_imm: assert property (p_add_imm)
    else $error("add immediate result or carry wrong");

  property p_sub_imm;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && op == OP_SUB_AI) |->
        (flagsReg.c == ($past(accReg) >= instrReg.imm) &&
         flagsReg.z == ($past(accReg) == instrReg.imm));
  endproperty
  a_sub_imm: assert property (p_sub_imm)
    else $error("subtract immediate flags wrong");

  property p_logic_flags;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && isLogic(op)) |->
        (flagsReg.c == $past(flagsReg.c) && flagsReg.dc == $past(flagsReg.dc));
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic operation touched carry flags");

  property p_compare_skip;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && op == OP_CMP_SKIP) |->
        (skipReg == ($past(accReg) == instrReg.imm) &&
         costReg == 3'(1 + skipReg) && $stable(accReg));
  endproperty
  a_compare_skip: assert property (p_compare_skip)
    else $error("compare skip or cost wrong");

  property p_n_cost;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && chargesN(op)) |->
        (costReg == (instrReg.addr >= SYS_BASE ? 3'h1 : 3'h2));
  endproperty
  a_n_cost: assert property (p_n_cost)
    else $error("memory write cost wrong");

  property p_bit_flags;
    @(posedge clk) disable iff (!arst_n)
      (doneReg && op inside {OP_BCLR, OP_BSET, OP_BZ_BCLR, OP_BZ_BSET}) |->
        ($stable(flagsReg) && memWrReg);
  endproperty
  a_bit_flags: assert property (p_bit_flags)
    else $error("bit operation changed flags or skipped write");
endmodule // instr_exec

// [sim/mem_model.sv]
// Purpose: data and program memory facing the execute core
// Assumes: read data is wanted one cycle after the read strobe
// Notes:   idle read buses toggle so stale data is never trusted
`timescale 1ns/10ps
module mem_model (
  // clock
  input  wire logic                    clk,
  // data memory
  input  wire logic [exec_pkg::AW-1:0] memAddr,
  input  wire logic                    memRd,
  input  wire logic                    memWr,
  input  wire logic [exec_pkg::DW-1:0] memWdata,
  output logic      [exec_pkg::DW-1:0] memRdata,
  // program memory
  input  wire logic [exec_pkg::PW-1:0] progAddr,
  input  wire logic                    progRd,
  output logic      [exec_pkg::PW-1:0] progData
);
  import exec_pkg::*;
  logic [DW-1:0] ram [0:511];

  initial begin
    memRdata = 8'h00;
    progData = 16'h0000;
  end

  // write on strobe, answer a read one cycle later, else toggle
  always @(posedge clk) begin
    if (memWr) begin
      ram[memAddr] <= memWdata;
    end
    memRdata <= memRd ? ram[memAddr] : ~memRdata;
    progData <= progRd ? {progAddr[7:0] ^ 8'hA5, progAddr[15:8] + 8'h3C}
                       : ~progData;
  end
endmodule // mem_model

// [sim/mcu_instruction_execute_bench.sv]
// Purpose: self-checking bench for the instruction execute core
// Assumes: one instruction in flight, memory model answers one cycle after the read strobe
// Notes:   flags are compared as {c, dc, z}
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end \
end
module mcu_instruction_execute_bench;
  import exec_pkg::*;
  logic          clk;
  logic          arst_n;
  logic          ce;
  logic          issueValid;
  instr_t        issueInstr;
  logic          bankSel;
  logic          readyReg;
  logic          doneReg;
  logic [2:0]    costReg;
  logic          skipReg;
  logic [AW-1:0] memAddr;
  logic          memRd;
  logic          memWr;
  logic [DW-1:0] memWdata;
  logic [DW-1:0] memRdata;
  logic [7:0]    yValue;
  logic [7:0]    zValue;
  logic [PW-1:0] progAddr;
  logic          progRd;
  logic [PW-1:0] progData;
  logic [DW-1:0] accReg;
  logic [DW-1:0] rVal;
  flags_t        flagsReg;
  int            miscompares = 0;
  int            tests_run = 0;

  instr_exec DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
    .issueValid(issueValid), .issueInstr(issueInstr), .bankSel(bankSel),
    .readyReg(readyReg), .doneReg(doneReg), .costReg(costReg),
    .skipReg(skipReg), .memAddrReg(memAddr), .memRdReg(memRd),
    .memWrReg(memWr), .memWdataReg(memWdata), .memRdata(memRdata),
    .yValue(yValue), .zValue(zValue), .progAddrReg(progAddr),
    .progRdReg(progRd), .progData(progData), .accReg(accReg),
    .rReg(rVal), .flagsReg(flagsReg));

  mem_model mem (.clk(clk), .memAddr(memAddr), .memRd(memRd),
    .memWr(memWr), .memWdata(memWdata), .memRdata(memRdata),
    .progAddr(progAddr), .progRd(progRd), .progData(progData));

  always #12.5 clk = ~clk;

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // issue one instruction and wait past its completion and write
  task automatic run(input op_t op, input logic [7:0] addr, imm,
                     input logic [2:0] bitSel = 3'h0);
    int n;
    n = 0;
    while (readyReg !== 1'b1) begin
      @(posedge clk);
      #1;
      if (++n > 20) begin
        miscompares++;
        report_and_stop();
      end
    end
    issueInstr = '{op: op, addr: addr, imm: imm, bitSel: bitSel};
    issueValid = 1'b1;
    @(posedge clk);
    #1;
    issueValid = 1'b0;
    n = 0;
    while (doneReg !== 1'b1) begin
      @(posedge clk);
      #1;
      if (++n > 20) begin
        miscompares++;
        report_and_stop();
      end
    end
    @(posedge clk);
    #1;
  endtask

  // accumulator a, carry and digit carry both c
  task automatic setAC(input logic [7:0] a, input logic c);
    run(OP_MOV_AI, 8'h00, c ? 8'hFF : 8'h00);
    run(OP_ADD_AI, 8'h00, c ? 8'h01 : 8'h00);
    run(OP_MOV_AI, 8'h00, a);
  endtask

  function automatic logic [10:0] add8(input logic [7:0] a, b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    s = a + b + cin;
    lo = a[3:0] + b[3:0] + cin;
    return {s[8], lo[4], s[7:0] == 8'h00, s[7:0]};
  endfunction

  // kind: 0 adc 1 sbc 2 and 3 or 4 xor 5 add 6 sub; dst: 0 A 1 A+M 2 M
  task automatic alu(input op_t op, input int kind, input logic [7:0] a, m,
                     input logic cin, input logic [7:0] addr, input int dst);
    logic [10:0] e;
    logic [7:0]  r;
    setAC(a, cin);
    mem.ram[{1'b0, addr}] = m;
    run(op, addr, m);
    case (kind)
      0: e = add8(a, m, cin);
      1: e = add8(a, ~m, cin);
      5: e = add8(a, m, 1'b0);
      6: e = add8(a, ~m, 1'b1);
      default: begin
        r = kind == 2 ? a & m : kind == 3 ? a | m : a ^ m;
        e = {cin, cin, r == 8'h00, r};
      end
    endcase
    `CHK(flagsReg, flags_t'(e[10:8]))
    if (dst != 2) `CHK(accReg, e[7:0])
    if (dst != 0) `CHK(mem.ram[{1'b0, addr}], e[7:0])
    if (dst == 2) `CHK(accReg, a)
    `CHK(costReg, (dst != 0 && addr < SYS_BASE) ? COST_TABLE : COST_ONE)
  endtask

  task automatic t_move;
    setAC(8'h5A, 1'b1);
    bankSel = 1'b1;
    mem.ram[9'h110] = 8'h37;
    mem.ram[9'h088] = 8'h11;
    mem.ram[9'h021] = 8'h00;
    run(OP_MOV_AM, 8'h10, 8'h00);
    `CHK(accReg, 8'h37)
    `CHK(flagsReg, flags_t'(3'b110))
    run(OP_MOV_MA, 8'h20, 8'h00);
    `CHK(mem.ram[9'h120], 8'h37)
    run(OP_B0MOV_AM, 8'h21, 8'h00);
    `CHK(flagsReg, flags_t'(3'b111))
    run(OP_B0MOV_MA, 8'h22, 8'h00);
    `CHK(mem.ram[9'h022], 8'h00)
    run(OP_B0MOV_MI, 8'h87, 8'hC3);
    `CHK(mem.ram[9'h087], 8'hC3)
    run(OP_B0MOV_MI, 8'h88, 8'hC3);
    `CHK(mem.ram[9'h088], 8'h11)
    `CHK(costReg, COST_ONE)
    $display("move test finished");
  endtask

  task automatic t_exchange;
    setAC(8'h12, 1'b0);
    bankSel = 1'b0;
    mem.ram[9'h030] = 8'h34;
    run(OP_XCH, 8'h30, 8'h00);
    `CHK({accReg, mem.ram[9'h030]}, 16'h3412)
    `CHK(costReg, COST_TABLE)
    bankSel = 1'b1;
    mem.ram[9'h081] = 8'h77;
    run(OP_BZ_XCH, 8'h81, 8'h00);
    `CHK({accReg, mem.ram[9'h081]}, 16'h7734)
    `CHK({flagsReg, costReg}, {3'b001, COST_ONE})
    yValue = 8'h12;
    zValue = 8'h34;
    run(OP_TBLRD, 8'h00, 8'h00);
    `CHK({rVal, accReg}, {8'h34 ^ 8'hA5, 8'h12 + 8'h3C})
    `CHK({flagsReg, costReg}, {3'b001, COST_TABLE})
    $display("exchange and table test finished");
  endtask

  task automatic t_arith;
    bankSel = 1'b0;
    alu(OP_ADD_AI, 5, 8'h0F, 8'h01, 1'b1, 8'h00, 0);
    alu(OP_ADD_AI, 5, 8'hF0, 8'h10, 1'b0, 8'h00, 0);
    alu(OP_ADC_AM, 0, 8'h01, 8'hFE, 1'b1, 8'h10, 0);
    alu(OP_ADC_MA, 0, 8'h7F, 8'h80, 1'b0, 8'h11, 1);
    alu(OP_ADD_AM, 5, 8'h88, 8'h88, 1'b1, 8'h12, 0);
    alu(OP_ADD_MA, 5, 8'h01, 8'h02, 1'b0, 8'h84, 1);
    alu(OP_B0ADD, 5, 8'h0E, 8'h03, 1'b0, 8'h13, 2);
    alu(OP_SBC_AM, 1, 8'h10, 8'h01, 1'b0, 8'h14, 0);
    alu(OP_SBC_MA, 1, 8'h05, 8'h05, 1'b1, 8'h15, 1);
    alu(OP_SUB_AM, 6, 8'h00, 8'h01, 1'b0, 8'h16, 0);
    alu(OP_SUB_MA, 6, 8'h33, 8'h22, 1'b0, 8'h86, 1);
    alu(OP_SUB_AI, 6, 8'h80, 8'h80, 1'b0, 8'h00, 0);
    alu(OP_AND_AM, 2, 8'hF0, 8'h0F, 1'b1, 8'h17, 0);
    alu(OP_AND_MA, 2, 8'hF3, 8'h3F, 1'b0, 8'h18, 2);
    alu(OP_AND_AI, 2, 8'hAA, 8'hFF, 1'b1, 8'h00, 0);
    alu(OP_OR_AM, 3, 8'h00, 8'h00, 1'b0, 8'h19, 0);
    alu(OP_OR_MA, 3, 8'h10, 8'h01, 1'b1, 8'h83, 2);
    alu(OP_OR_AI, 3, 8'h40, 8'h04, 1'b0, 8'h00, 0);
    alu(OP_XOR_AM, 4, 8'h5A, 8'h5A, 1'b1, 8'h1A, 0);
    alu(OP_XOR_MA, 4, 8'h5A, 8'hA5, 1'b0, 8'h1B, 2);
    alu(OP_XOR_AI, 4, 8'h0F, 8'h01, 1'b1, 8'h00, 0);
    $display("arithmetic and logic test finished");
  endtask

  task automatic t_shift;
    setAC(8'h00, 1'b1);
    bankSel = 1'b0;
    mem.ram[9'h050] = 8'h3C;
    mem.ram[9'h051] = 8'h02;
    mem.ram[9'h086] = 8'h81;
    mem.ram[9'h053] = 8'hAA;
    run(OP_SWAP, 8'h50, 8'h00);
    `CHK({accReg, flagsReg}, {8'hC3, 3'b111})
    run(OP_SWAP_MEM, 8'h50, 8'h00);
    `CHK({mem.ram[9'h050], costReg}, {8'hC3, COST_TABLE})
    run(OP_RRC, 8'h51, 8'h00);
    `CHK({accReg, flagsReg}, {8'h81, 3'b011})
    run(OP_RLC_MEM, 8'h86, 8'h00);
    `CHK({mem.ram[9'h086], flagsReg}, {8'h02, 3'b111})
    `CHK(costReg, COST_ONE)
    run(OP_CLR, 8'h53, 8'h00);
    `CHK({mem.ram[9'h053], flagsReg}, {8'h00, 3'b111})
    bankSel = 1'b1;
    mem.ram[9'h154] = 8'hFF;
    mem.ram[9'h056] = 8'hFF;
    mem.ram[9'h085] = 8'h00;
    run(OP_BCLR, 8'h54, 8'h00, 3'h3);
    `CHK({mem.ram[9'h154], costReg}, {8'hF7, COST_TABLE})
    run(OP_BZ_BCLR, 8'h56, 8'h00, 3'h0);
    `CHK(mem.ram[9'h056], 8'hFE)
    run(OP_BZ_BSET, 8'h85, 8'h00, 3'h6);
    `CHK({mem.ram[9'h085], costReg}, {8'h40, COST_ONE})
    run(OP_BSET, 8'h54, 8'h00, 3'h3);
    `CHK({mem.ram[9'h154], flagsReg}, {8'hFF, 3'b111})
    $display("swap rotate and bit test finished");
  endtask

  task automatic t_compare;
    setAC(8'h40, 1'b0);
    run(OP_CMP_SKIP, 8'h00, 8'h41);
    `CHK({flagsReg, skipReg, costReg}, {4'b0000, COST_ONE})
    run(OP_CMP_SKIP, 8'h00, 8'h40);
    `CHK({flagsReg, skipReg, costReg}, {4'b1011, COST_TABLE})
    run(OP_CMP_SKIP, 8'h00, 8'h3F);
    `CHK({flagsReg, skipReg, accReg}, {4'b1000, 8'h40})
    $display("compare test finished");
  endtask

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    issueValid = 1'b0;
    issueInstr = '0;
    bankSel = 1'b0;
    yValue = 8'h00;
    zValue = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    `CHK({readyReg, accReg}, {1'b0, ACC_RESET})
    arst_n = 1'b1;
    t_move();
    t_exchange();
    t_arith();
    t_shift();
    t_compare();
    report_and_stop();
  end
endmodule // mcu_instruction_execute_bench
